// >>> hw/ccg_consts.vh
// Purpose: constants for the clock generator two-wire configuration target.
// Assumes: included by ccg_i2c_config.v only.
// Notes: offsets are register byte numbers on the two-wire bus.
`ifndef CCG_CONSTS_VH
`define CCG_CONSTS_VH
`define CCG_BASE_ADDR 7'h68
`define CCG_OFF_GEN_CTRL 8'h00
`define CCG_OFF_VARIANT 8'h01
`define CCG_OFF_XTAL_TRIM 8'h02
`define CCG_OFF_L3_REF 8'h03
`define CCG_OFF_L3_FB_LO 8'h04
`define CCG_OFF_L3_FB_HI 8'h05
`define CCG_NUM_REGS 6
`define CCG_RST_GEN_CTRL 8'h00
`define CCG_RST_VARIANT 8'h00
`define CCG_RST_XTAL_TRIM 8'h11
`define CCG_RST_L3_REF 8'h19
`define CCG_RST_L3_FB_LO 8'he0
`define CCG_RST_L3_FB_HI 8'h01
`define CCG_GEN_RSVD_MASK 8'hfd
`define CCG_FB_HI_MASK 8'h07
`define CCG_BIT_NVM_PROG 7
`define CCG_BIT_ADDR_HI 6
`define CCG_BIT_ADDR_LO 5
`define CCG_BIT_SPREAD 4
`define CCG_BIT_DIV1_SRC 3
`define CCG_BIT_L3_REF_SEL 2
`define CCG_BIT_NVM_LOCK 0
`define CCG_BIT_BYP1 7
`define CCG_BIT_BYP2 6
`endif

// >>> hw/ccg_i2c_config.v
// Purpose: two-wire bus target holding the first configuration bytes of a clock generator.
// Assumes: bus pins are synchronous to clk_sys and already glitch free.
// Notes: writes are staged and committed together at stop.
//
// Summary of operation
// - Answer only at the selected one of four addresses
// - Block writes and block reads of bytes
// - First write byte sets the register pointer
// - Pointer increments per byte, MSB first
// - Block may end after any byte
// - Stage write bytes, commit all at stop
// - Byte 0 bits 6:5 select the address
// - Byte 0 bit 4 enables loop1 spread
// - Bits 3 and 2 pick clock sources
// - Byte 2 holds two four-bit load trims
// - Byte 3 bits 7:6 reference bypass stages
// - Byte 3 bits 5:0 reference divider, default 25
// - Byte 4 feedback divider low byte
// - Byte 5 bits 2:0 feedback divider high bits
`timescale 1ns/1ps
`include "ccg_consts.vh"
module ccg_i2c_config #(
	parameter NREG = `CCG_NUM_REGS
) (
	input wire clk_sys, // System clock.
	input wire rst, // Asynchronous reset, active high.
	input wire scl_in, // Bus clock level.
	input wire serial_data_line_in, // Bus data level.
	output reg serial_data_line_out, // Data drive value, always low when enabled.
	output reg serial_data_line_oe, // High while pulling data low.
	output wire [1:0] addr_select, // Selected address index.
	output wire loop1_spread_enable, // Loop 1 spread enable.
	output wire out_divider1_source_select, // Divider 1 source, 1 = crystal.
	output wire loop3_reference_select, // Loop 3 reference, 1 = divider-2 seed.
	output wire nvm_programmed, // Nonvolatile memory programmed flag.
	output wire nvm_write_lock, // Nonvolatile memory write lock.
	output wire [7:0] variant_id, // Variant identifier byte.
	output wire [3:0] xtal_trim_in_pin, // Load trim for input pin.
	output wire [3:0] xtal_trim_out_pin, // Load trim for output pin.
	output wire loop3_ref_bypass_div1, // Loop 3 divide-by-1 bypass.
	output wire loop3_ref_bypass_div2, // Loop 3 divide-by-2 bypass.
	output wire [5:0] loop3_ref_integer_divider, // Loop 3 reference divider.
	output wire [10:0] loop3_feedback_divider, // Loop 3 feedback divider.
	output wire busy // High between start and stop.
);
	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_AACK = 3'd2;
	localparam ST_WBYTE = 3'd3;
	localparam ST_WACK = 3'd4;
	localparam ST_RBYTE = 3'd5;
	localparam ST_RACK = 3'd6;

	reg [7:0] regs_reg [0:NREG-1];
	reg [7:0] stage_reg [0:NREG-1];
	reg [NREG-1:0] stage_vld_reg;
	reg scl_d_reg;
	reg sda_d_reg;
	reg [2:0] state_reg;
	reg [7:0] shift_reg;
	reg [2:0] bit_reg;
	reg [7:0] ptr_reg;
	reg ptr_seen_reg;
	reg busy_reg;
	reg addr_full_reg;
	wire scl_rise = scl_in & ~scl_d_reg;
	wire scl_fall = ~scl_in & scl_d_reg;
	wire start_det = scl_in & scl_d_reg & sda_d_reg & ~serial_data_line_in;
	wire stop_det = scl_in & scl_d_reg & ~sda_d_reg & serial_data_line_in;
	wire [7:0] rd_byte = (ptr_reg < NREG) ? regs_reg[ptr_reg[2:0]] : 8'h00;
	wire [7:0] gen = regs_reg[0];
	wire [7:0] rx_byte = {shift_reg[6:0], serial_data_line_in};
	integer i;

	assign addr_select = gen[`CCG_BIT_ADDR_HI:`CCG_BIT_ADDR_LO];
	assign loop1_spread_enable = gen[`CCG_BIT_SPREAD];
	assign out_divider1_source_select = gen[`CCG_BIT_DIV1_SRC];
	assign loop3_reference_select = gen[`CCG_BIT_L3_REF_SEL];
	assign nvm_programmed = gen[`CCG_BIT_NVM_PROG];
	assign nvm_write_lock = gen[`CCG_BIT_NVM_LOCK];
	assign variant_id = regs_reg[1];
	assign xtal_trim_out_pin = regs_reg[2][7:4];
	assign xtal_trim_in_pin = regs_reg[2][3:0];
	assign loop3_ref_bypass_div1 = regs_reg[3][`CCG_BIT_BYP1];
	assign loop3_ref_bypass_div2 = regs_reg[3][`CCG_BIT_BYP2];
	assign loop3_ref_integer_divider = regs_reg[3][5:0];
	assign loop3_feedback_divider = {regs_reg[5][2:0], regs_reg[4]};
	assign busy = busy_reg;

	function [7:0] rst_val;
		input [2:0] idx;
		begin
			case (idx)
				3'd0: rst_val = `CCG_RST_GEN_CTRL;
				3'd1: rst_val = `CCG_RST_VARIANT;
				3'd2: rst_val = `CCG_RST_XTAL_TRIM;
				3'd3: rst_val = `CCG_RST_L3_REF;
				3'd4: rst_val = `CCG_RST_L3_FB_LO;
				default: rst_val = `CCG_RST_L3_FB_HI;
			endcase
		end
	endfunction

	function [7:0] wr_mask;
		input [2:0] idx;
		begin
			case (idx)
				3'd0: wr_mask = `CCG_GEN_RSVD_MASK;
				3'd5: wr_mask = `CCG_FB_HI_MASK;
				default: wr_mask = 8'hff;
			endcase
		end
	endfunction

	// Registers change only at stop, all staged bytes together.
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					regs_reg[g] <= rst_val(g);
				end else if (stop_det && busy_reg && stage_vld_reg[g]) begin
					regs_reg[g] <= stage_reg[g] & wr_mask(g);
				end
			end
		end
	endgenerate

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bit_reg <= 3'd0;
			ptr_reg <= 8'h00;
			ptr_seen_reg <= 1'b0;
			busy_reg <= 1'b0;
			addr_full_reg <= 1'b0;
			stage_vld_reg <= {NREG{1'b0}};
			serial_data_line_out <= 1'b0;
			serial_data_line_oe <= 1'b0;
			for (i = 0; i < NREG; i = i + 1) begin
				stage_reg[i] <= 8'h00;
			end
		end else begin
			scl_d_reg <= scl_in;
			sda_d_reg <= serial_data_line_in;
			serial_data_line_out <= 1'b0;
			if (start_det) begin
				// A repeated start keeps staged bytes so they commit at the final stop.
				state_reg <= ST_ADDR;
				bit_reg <= 3'd0;
				busy_reg <= 1'b1;
				addr_full_reg <= 1'b0;
				serial_data_line_oe <= 1'b0;
			end else if (stop_det) begin
				// Stop ends any block without a length check.
				state_reg <= ST_IDLE;
				busy_reg <= 1'b0;
				stage_vld_reg <= {NREG{1'b0}};
				serial_data_line_oe <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						serial_data_line_oe <= 1'b0;
					end
					ST_ADDR: begin
						if (scl_rise) begin
							shift_reg <= rx_byte;
							bit_reg <= bit_reg + 3'd1;
							if (bit_reg == 3'd7) begin
								addr_full_reg <= 1'b1;
							end
						end
						// The clock fall right after a start carries no bits, so wait for a full byte.
						if (scl_fall && addr_full_reg) begin
							if (shift_reg[7:1] == (`CCG_BASE_ADDR | {5'd0, addr_select})) begin
								serial_data_line_oe <= 1'b1;
								ptr_seen_reg <= 1'b0;
								state_reg <= ST_AACK;
							end else begin
								state_reg <= ST_IDLE;
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							if (shift_reg[0]) begin
								// Read data begins at the present pointer.
								serial_data_line_oe <= ~rd_byte[7];
								shift_reg <= rd_byte;
								state_reg <= ST_RBYTE;
							end else begin
								serial_data_line_oe <= 1'b0;
								state_reg <= ST_WBYTE;
							end
						end
					end
					ST_WBYTE: begin
						if (scl_rise) begin
							shift_reg <= rx_byte;
							bit_reg <= bit_reg + 3'd1;
						end
						if (scl_fall && bit_reg == 3'd0) begin
							serial_data_line_oe <= 1'b1;
							state_reg <= ST_WACK;
							if (!ptr_seen_reg) begin
								// First byte is the register start address.
								ptr_reg <= shift_reg;
								ptr_seen_reg <= 1'b1;
							end else begin
								if (ptr_reg < NREG) begin
									stage_reg[ptr_reg[2:0]] <= shift_reg;
									stage_vld_reg[ptr_reg[2:0]] <= 1'b1;
								end
								// Advance pointer after each data byte.
								ptr_reg <= ptr_reg + 8'h01;
							end
						end
					end
					ST_WACK: begin
						if (scl_fall) begin
							serial_data_line_oe <= 1'b0;
							state_reg <= ST_WBYTE;
						end
					end
					ST_RBYTE: begin
						if (scl_fall) begin
							bit_reg <= bit_reg + 3'd1;
							if (bit_reg == 3'd7) begin
								serial_data_line_oe <= 1'b0;
								// Advance pointer after each read byte.
								ptr_reg <= ptr_reg + 8'h01;
								state_reg <= ST_RACK;
							end else begin
								serial_data_line_oe <= ~shift_reg[6];
								shift_reg <= {shift_reg[6:0], 1'b0};
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							shift_reg[0] <= serial_data_line_in;
						end
						if (scl_fall) begin
							// A missing acknowledge ends the read.
							if (shift_reg[0]) begin
								state_reg <= ST_IDLE;
							end else begin
								serial_data_line_oe <= ~rd_byte[7];
								shift_reg <= rd_byte;
								bit_reg <= 3'd0;
								state_reg <= ST_RBYTE;
							end
						end
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule // ccg_i2c_config

// >>> tb/ccg_i2c_monitor.sv
// Purpose: port checker for the two-wire configuration target.
// Assumes: bus pins are sampled on clk_sys as the target samples them.
// Notes: two counters track the cycles since the last start and stop.
`timescale 1ns/1ps
module ccg_i2c_monitor (
	input wire clk_sys, // System clock.
	input wire rst, // Reset, active high.
	input wire scl_in, // Bus clock.
	input wire serial_data_line_in, // Bus data.
	input wire serial_data_line_out, // Data drive value.
	input wire serial_data_line_oe, // Data drive enable.
	input wire busy, // Transfer in progress.
	input wire [5:0] loop3_ref_integer_divider, // Reference divider.
	input wire [10:0] loop3_feedback_divider // Feedback divider.
);
	reg scl_q, sda_q;
	reg [3:0] n_stp, n_sta;
	wire hi = scl_q & scl_in;
	wire stp = hi & ~sda_q & serial_data_line_in;
	wire sta = hi & sda_q & ~serial_data_line_in;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			n_stp <= 4'hf;
			n_sta <= 4'hf;
		end else begin
			scl_q <= scl_in;
			sda_q <= serial_data_line_in;
			n_stp <= stp ? 4'h0 : n_stp + {3'h0, n_stp != 4'hf};
			n_sta <= sta ? 4'h0 : n_sta + {3'h0, n_sta != 4'hf};
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_commit;
		$changed({loop3_feedback_divider, loop3_ref_integer_divider}) |-> n_stp < 4'h5;
	endproperty
	a_commit: assert property (p_commit) else $error("config moved away from a stop");
	property p_oe_scl;
		$changed(serial_data_line_oe) |-> !scl_in && !$past(scl_in);
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("data drive moved with clock high");
	property p_oe_busy;
		serial_data_line_oe |-> busy && !serial_data_line_out;
	endproperty
	a_oe_busy: assert property (p_oe_busy) else $error("data driven outside a transfer");
	property p_busy_sta;
		$rose(busy) |-> n_sta < 4'h4;
	endproperty
	a_busy_sta: assert property (p_busy_sta) else $error("busy rose without start");
	property p_busy_stp;
		$fell(busy) |-> n_stp < 4'h4;
	endproperty
	a_busy_stp: assert property (p_busy_stp) else $error("busy fell without stop");
	property p_stop_idle;
		stp |-> ##[1:4] (!busy && !serial_data_line_oe);
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("not idle after stop");
	property p_rst_ref;
		$fell(rst) |-> loop3_ref_integer_divider == 6'h19;
	endproperty
	a_rst_ref: assert property (p_rst_ref) else $error("reference divider default wrong");
	property p_rst_fb;
		$fell(rst) |-> loop3_feedback_divider == 11'h1e0;
	endproperty
	a_rst_fb: assert property (p_rst_fb) else $error("feedback divider default wrong");
endmodule // ccg_i2c_monitor
bind ccg_i2c_config ccg_i2c_monitor i_mon (.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in),
	.serial_data_line_in(serial_data_line_in), .serial_data_line_out(serial_data_line_out),
	.serial_data_line_oe(serial_data_line_oe), .busy(busy),
	.loop3_ref_integer_divider(loop3_ref_integer_divider),
	.loop3_feedback_divider(loop3_feedback_divider));

// >>> tb/ccg_bus_ctl.sv
// Purpose: two-wire bus controller model.
// Assumes: the bench resolves the data wire with a pull-up.
// Notes: each phase lasts four clk_sys cycles, above the three the target needs.
`timescale 1ns/1ps
module ccg_bus_ctl (
	input wire clk_sys, // System clock.
	input wire sda_wire, // Resolved data level.
	output reg scl, // Bus clock.
	output reg sda_rel // High releases data, low pulls it down.
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task tick;
		repeat (4) @(posedge clk_sys);
	endtask
	task start;
		begin
			sda_rel <= 1'b1;
			tick;
			scl <= 1'b1;
			tick;
			sda_rel <= 1'b0;
			tick;
			scl <= 1'b0;
			tick;
		end
	endtask
	task bitx(input b, output r);
		begin
			sda_rel <= b;
			tick;
			scl <= 1'b1;
			tick;
			r = sda_wire;
			scl <= 1'b0;
			tick;
		end
	endtask
	// whole bytes, MSB first, last read byte left unacknowledged.
	task xfer(input [7:0] d, input ak, output [7:0] q, output ar);
		integer j;
		begin
			for (j = 7; j >= 0; j = j - 1)
				bitx(d[j], q[j]);
			bitx(ak, ar);
		end
	endtask
	// stop only after a complete byte.
	task stop;
		begin
			sda_rel <= 1'b0;
			tick;
			scl <= 1'b1;
			tick;
			sda_rel <= 1'b1;
			tick;
		end
	endtask
endmodule // ccg_bus_ctl

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the two-wire configuration target.
// Assumes: the controller model drives the bus, data has a pull-up.
// Notes: a register image in the bench predicts every readback.
`timescale 1ns/1ps
module tb_top;
	reg clk_sys, rst, a;
	reg [7:0] q;
	reg [7:0] m [0:5];
	reg [6:0] dev, old;
	integer n_errors, n_tests, i, off, ptr;
	wire scl_in, sda_rel, sda_out, sda_oe, busy, sp, d1s, rsel, npr, nlk, b1, b2;
	wire [1:0] asel;
	wire [7:0] vid;
	wire [3:0] ti_w, to_w;
	wire [5:0] rdiv;
	wire [10:0] fdiv;
	wire sda_wire = sda_rel & ~(sda_oe & ~sda_out);
	wire [47:0] obs = {npr, asel, sp, d1s, rsel, 1'b0, nlk, vid, to_w, ti_w, b1, b2, rdiv,
		fdiv[7:0], 5'h00, fdiv[10:8]};
	ccg_i2c_config i_dut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in),
		.serial_data_line_in(sda_wire), .serial_data_line_out(sda_out),
		.serial_data_line_oe(sda_oe), .addr_select(asel), .loop1_spread_enable(sp),
		.out_divider1_source_select(d1s), .loop3_reference_select(rsel), .nvm_programmed(npr),
		.nvm_write_lock(nlk), .variant_id(vid), .xtal_trim_in_pin(ti_w), .xtal_trim_out_pin(to_w),
		.loop3_ref_bypass_div1(b1), .loop3_ref_bypass_div2(b2), .loop3_ref_integer_divider(rdiv),
		.loop3_feedback_divider(fdiv), .busy(busy));
	ccg_bus_ctl i_ctl (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl_in), .sda_rel(sda_rel));
	function automatic [47:0] expv();
		expv = {m[0], m[1], m[2], m[3], m[4], m[5]};
	endfunction
	function automatic [7:0] rd_exp(input integer p);
		rd_exp = (p < 6) ? m[p] : 8'h00;
	endfunction
	task check(input string what, input [47:0] seen, input [47:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				$display("BAD %s expected %h seen %h", what, exp, seen);
				n_errors = n_errors + 1;
			end
		end
	endtask
	task head(input [6:0] d, input rw);
		begin
			i_ctl.start;
			i_ctl.xfer({d, rw}, 1'b1, q, a);
			check("address ack", a, 1'b0);
		end
	endtask
	task wr(input integer o, input integer cnt, input [7:0] b0);
		integer j;
		reg [7:0] v [0:5];
		begin
			head(dev, 1'b0);
			i_ctl.xfer(o, 1'b1, q, a);
			for (j = 0; j < cnt; j = j + 1) begin
				v[j] = (o + j == 0) ? b0 : $urandom;
				i_ctl.xfer(v[j], 1'b1, q, a);
				check("data ack", a, 1'b0);
			end
			check("staged", obs, expv());
			i_ctl.stop;
			for (j = 0; j < cnt; j = j + 1)
				m[o + j] = (o + j == 0) ? v[j] & 8'hfd : (o + j == 5) ? v[j] & 8'h07 : v[j];
			ptr = o + cnt;
			dev = 7'h68 + m[0][6:5];
			check("committed", obs, expv());
		end
	endtask
	task rd(input integer o, input seq, input integer cnt);
		integer j;
		begin
			if (seq) begin
				head(dev, 1'b0);
				i_ctl.xfer(o, 1'b1, q, a);
				ptr = o;
			end
			head(dev, 1'b1);
			for (j = 0; j < cnt; j = j + 1) begin
				i_ctl.xfer(8'hff, j == cnt - 1, q, a);
				check("read byte", q, rd_exp(ptr));
				ptr = ptr + 1;
			end
			i_ctl.stop;
		end
	endtask
	task conclude;
		begin
			$display("tests %0d errors %0d", n_tests, n_errors);
			if (n_errors == 0 && n_tests > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		#400000;
		n_errors = n_errors + 1;
		conclude;
	end
	initial begin
		n_errors = 0;
		n_tests = 0;
		rst = 1'b1;
		{m[0], m[1], m[2], m[3], m[4], m[5]} = 48'h0000_1119_e001;
		dev = 7'h68;
		ptr = $urandom(53202);
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check("defaults", obs, expv());
		rd(0, 1'b1, 6);
		rd(0, 1'b0, 1);
		$display("test reset done");
		for (i = 0; i < 4; i = i + 1) begin
			off = 1 + $urandom % 4;
			wr(off, 1 + $urandom % (6 - off), 8'h00);
			rd(off, 1'b1, 6 - off);
		end
		$display("test blocks done");
		for (i = 1; i < 5; i = i + 1) begin
			old = dev;
			wr(0, 1, $urandom & 8'h9f | 8'h02 | ((i % 4) << 5));
			i_ctl.start;
			i_ctl.xfer({old, 1'b0}, 1'b1, q, a);
			check("old address", a, 1'b1);
			i_ctl.stop;
			rd(0, 1'b1, 2);
		end
		$display("test address done");
		head(dev, 1'b0);
		i_ctl.xfer(8'h06, 1'b1, q, a);
		i_ctl.xfer($urandom, 1'b1, q, a);
		check("high ack", a, 1'b0);
		i_ctl.stop;
		check("high dropped", obs, expv());
		wr(3, 0, 8'h00);
		rd(3, 1'b0, 3);
		$display("test pointer done");
		conclude;
	end
endmodule // tb_top
